// file: hdl/vffs_pkg.sv
package vffs_pkg;

	// ----------------------------------------------------------------
	// Geometry and register map
	// ----------------------------------------------------------------
	localparam int          VFFS_NBITS        = 32;
	localparam logic [11:0] ADDR_MASK         = 12'h000;
	localparam logic [11:0] ADDR_CMD          = 12'h004;
	localparam logic [11:0] ADDR_FAULT        = 12'h008;
	localparam logic [11:0] ADDR_PRED         = 12'h00c;
	localparam logic [11:0] ADDR_FLAGS        = 12'h010;
	localparam logic [11:0] ADDR_FPCTRL       = 12'h014;
	localparam logic [11:0] ADDR_TRAPCTRL     = 12'h018;
	localparam logic [11:0] ADDR_SYND         = 12'h01c;
	localparam logic [11:0] ADDR_PFX          = 12'h020;
	localparam logic [11:0] ADDR_RESTART      = 12'h024;
	localparam logic [11:0] ADDR_FADDR        = 12'h028;
	localparam logic [11:0] ADDR_SCALAR       = 12'h02c;
	localparam logic [31:0] MASK_RST          = 32'h0000_0000;
	localparam logic [5:0]  VEC_TRAP_CLASS    = 6'h19;
	localparam logic [1:0]  AXI_OKAY          = 2'h0;
	localparam logic [1:0]  AXI_DECERR        = 2'h3;

	// ----------------------------------------------------------------
	// Commands written to the command register
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_SET_ALL_TRUE,
		CMD_MASK_WRITE,
		CMD_MASK_READ,
		CMD_MASK_READ_FLAGS,
		CMD_PTEST,
		CMD_TERM_COMPARE
	} vffs_cmd_e;

	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} vffs_flags_s;

endpackage : vffs_pkg

// file: hdl/vffs_top.sv
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: Fault mask shaped like a predicate register.
// R2: Set-all-true makes every mask element TRUE.
// R3: Failed load clears element and all higher.
// R4: Loads never turn a mask element TRUE.
// R5: Only named instructions read or write mask.
// R6: Mask accesses take effect in program order.
// R7: Narrow scalar results zero upper destination bits.
// R8: N is first active element value.
// R9: Z set when no active element TRUE.
// R10: C cleared when last active element TRUE.
// R11: V cleared except by termination compares.
// R12: Unpredicated operations treat all elements active.
// R13: Provide more and last-or-none condition aliases.
// R14: Continue when N equals V, else detected.
// R15: Half precision uses only its own flush control.
// R16: Half flush never sets input-denormal status.
// R17: Half format ignores alternative-half control.
// R18: Hierarchical trap controls, hypervisor field by host bit.
// R19: Vector traps report class 011001.
// R20: FP exceptions only from active elements.
// R21: Prefix restart address only if prefix unchanged state.
// R22: Prefix pair fetch aborts pick reported address.
// R23: Element TRUE when its lowest bit is one.
// R24: First lowest, last highest active element.
// R25: Software sets mask true before first-fault loads.
module vffs_top
	import vffs_pkg::*;
#(
	parameter int NBITS = VFFS_NBITS
) (
	input  wire logic        CORE_CLK_I,
	input  wire logic        SRST_I,
	input  wire logic [11:0] S_AXI_AWADDR_I,
	input  wire logic        S_AXI_AWVALID_I,
	output logic             S_AXI_AWREADY_O,
	input  wire logic [31:0] S_AXI_WDATA_I,
	input  wire logic [3:0]  S_AXI_WSTRB_I,
	input  wire logic        S_AXI_WVALID_I,
	output logic             S_AXI_WREADY_O,
	output logic [1:0]       S_AXI_BRESP_O,
	output logic             S_AXI_BVALID_O,
	input  wire logic        S_AXI_BREADY_I,
	input  wire logic [11:0] S_AXI_ARADDR_I,
	input  wire logic        S_AXI_ARVALID_I,
	output logic             S_AXI_ARREADY_O,
	output logic [31:0]      S_AXI_RDATA_O,
	output logic [1:0]       S_AXI_RRESP_O,
	output logic             S_AXI_RVALID_O,
	input  wire logic        S_AXI_RREADY_I
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Element view: each element's low bit is kept in place and every other bit of the element is cleared.
	function automatic logic [31:0] elem_true(input logic [31:0] p, input logic [1:0] esz);
		logic [31:0] r;
		r = 32'h0;
		for (int i = 0; i < 32; i++) begin
			if ((i % (1 << esz)) == 0) begin
				r[i] = p[i]; // R23
			end
		end
		return r;
	endfunction : elem_true

	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction : wmerge

	// ----------------------------------------------------------------
	// Bus slave state
	// ----------------------------------------------------------------
	logic        aw_ff, w_ff, bvalid_ff, rvalid_ff;
	logic [11:0] awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [3:0]  wstrb_ff;
	logic [1:0]  bresp_ff, rresp_ff;
	logic        wr_go;
	logic        rd_go;

	// ----------------------------------------------------------------
	// Architectural state
	// ----------------------------------------------------------------
	logic [31:0] load_fault_mask_ff;
	logic [31:0] pred_ff;
	logic [31:0] fault_ff;
	logic [31:0] mask_rd_ff;
	vffs_flags_s flags_ff;
	logic [7:0]  fpctrl_ff;
	logic [7:0]  trapctrl_ff;
	logic [7:0]  synd_ff;
	logic [31:0] pfx_ff;
	logic [31:0] restart_ff;
	logic [31:0] faddr_ff;
	logic [31:0] scalar_ff;
	logic        idc_ff;

	assign S_AXI_AWREADY_O = !aw_ff && !bvalid_ff;
	assign S_AXI_WREADY_O  = !w_ff && !bvalid_ff;
	assign S_AXI_ARREADY_O = !rvalid_ff;
	assign S_AXI_BVALID_O  = bvalid_ff;
	assign S_AXI_BRESP_O   = bresp_ff;
	assign S_AXI_RVALID_O  = rvalid_ff;
	assign S_AXI_RDATA_O   = rdata_ff;
	assign S_AXI_RRESP_O   = rresp_ff;
	assign wr_go = aw_ff && w_ff && !bvalid_ff;
	assign rd_go = S_AXI_ARVALID_I && !rvalid_ff;

	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			aw_ff     <= 1'b0;
			w_ff      <= 1'b0;
			awaddr_ff <= 12'h0;
			wdata_ff  <= 32'h0;
			wstrb_ff  <= 4'h0;
		end else begin
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
				aw_ff     <= 1'b1;
				awaddr_ff <= S_AXI_AWADDR_I;
			end else if (wr_go) begin
				aw_ff <= 1'b0;
			end
			if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
				w_ff     <= 1'b1;
				wdata_ff <= S_AXI_WDATA_I;
				wstrb_ff <= S_AXI_WSTRB_I;
			end else if (wr_go) begin
				w_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Decoded write and command
	// ----------------------------------------------------------------
	logic        wr_known;
	logic        cmd_go;
	vffs_cmd_e   cmd;
	logic [1:0]  esz;
	logic        unpred;
	logic [31:0] gov;
	logic [31:0] src;
	logic [31:0] act;
	logic [31:0] tru;
	logic        first_t, last_t, any_t;
	logic [31:0] fault_clr;

	always_comb begin
		wr_known = 1'b1;
		case (awaddr_ff)
			ADDR_MASK, ADDR_CMD, ADDR_FAULT, ADDR_PRED, ADDR_FPCTRL,
			ADDR_TRAPCTRL, ADDR_PFX, ADDR_SCALAR: wr_known = 1'b1;
			default: wr_known = 1'b0;
		endcase
	end

	// Command word: [2:0] command, [5:4] element size log2, [6] unpredicated,
	// [7] term compare equal result, [8] term end of partition.
	assign cmd_go = wr_go && (awaddr_ff == ADDR_CMD) && wstrb_ff[0];
	assign cmd    = vffs_cmd_e'(wdata_ff[2:0]);
	assign esz    = wdata_ff[5:4];
	assign unpred = wdata_ff[6];
	assign gov    = unpred ? 32'hffff_ffff : pred_ff; // R12
	assign src    = (cmd == CMD_MASK_READ_FLAGS) ? load_fault_mask_ff : pred_ff;
	assign act    = elem_true(gov, esz);
	assign tru    = elem_true(src, esz) & act;

	always_comb begin
		first_t = 1'b0;
		last_t  = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			if (act[i]) begin
				first_t = tru[i]; // R24
			end
		end
		for (int i = 0; i < 32; i++) begin
			if (act[i]) begin
				last_t = tru[i]; // R24
			end
		end
	end
	assign any_t = |tru;

	// Element index of the failed load clears that element and every higher one.
	always_comb begin
		fault_clr = 32'h0;
		for (int i = 0; i < 32; i++) begin
			if (i >= int'(wdata_ff[4:0])) begin
				fault_clr[i] = 1'b1; // R3
			end
		end
	end

	// ----------------------------------------------------------------
	// Fault mask
	// ----------------------------------------------------------------
	// The mask is only updated from the serialised write path, so every
	// access lands in issue order without extra barriers.
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			load_fault_mask_ff <= MASK_RST;
		end else if (cmd_go && cmd == CMD_SET_ALL_TRUE) begin
			load_fault_mask_ff <= elem_true(32'hffff_ffff, esz); // R2 R1
		end else if (cmd_go && cmd == CMD_MASK_WRITE) begin
			load_fault_mask_ff <= elem_true(pred_ff, esz); // R5 R6
		end else if (wr_go && awaddr_ff == ADDR_FAULT && wstrb_ff[0]) begin
			load_fault_mask_ff <= load_fault_mask_ff & ~fault_clr; // R3 R4
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			mask_rd_ff <= 32'h0;
		end else if (cmd_go && (cmd == CMD_MASK_READ || cmd == CMD_MASK_READ_FLAGS)) begin
			mask_rd_ff <= load_fault_mask_ff & elem_true(gov, esz); // R5
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			pred_ff <= 32'h0;
		end else if (wr_go && awaddr_ff == ADDR_PRED) begin
			pred_ff <= wmerge(pred_ff, wdata_ff, wstrb_ff);
		end
	end

	// ----------------------------------------------------------------
	// Condition flags
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			flags_ff <= '0;
		end else if (cmd_go && (cmd == CMD_PTEST || cmd == CMD_MASK_READ_FLAGS)) begin
			flags_ff.n <= first_t; // R8
			flags_ff.z <= !any_t; // R9
			flags_ff.c <= !last_t; // R10
			flags_ff.v <= 1'b0; // R11
		end else if (cmd_go && cmd == CMD_TERM_COMPARE) begin
			flags_ff.n <= wdata_ff[7];
			flags_ff.z <= 1'b0;
			flags_ff.c <= 1'b0;
			flags_ff.v <= !wdata_ff[7] && wdata_ff[8]; // R11
		end
	end

	logic c_more, c_lastnone, c_cont;
	assign c_more     = flags_ff.c && !flags_ff.z; // R13
	assign c_lastnone = !flags_ff.c || flags_ff.z; // R13
	assign c_cont     = (flags_ff.n == flags_ff.v); // R14

	// ----------------------------------------------------------------
	// Half precision controls
	// ----------------------------------------------------------------
	// Control bits: [0] single flush, [1] half flush, [2] alternative half,
	// [3] operand is half, [4] operand denormal, [5] element active.
	logic half_flush, half_idc, fp_wr;
	assign half_flush = fpctrl_ff[3] && fpctrl_ff[1]; // R15
	assign half_idc   = fpctrl_ff[5] && fpctrl_ff[4] && !half_flush
		&& !(!fpctrl_ff[3] && fpctrl_ff[0]); // R16 R20
	assign fp_wr      = wr_go && awaddr_ff == ADDR_FPCTRL && wstrb_ff[0];

	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			fpctrl_ff <= 8'h0;
		end else if (fp_wr) begin
			fpctrl_ff <= wdata_ff[7:0];
		end
	end

	// A denormal seen in the cycle of a software clear still sets the status, so none is lost.
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			idc_ff <= 1'b0;
		end else if (half_idc) begin
			idc_ff <= 1'b1;
		end else if (fp_wr && wdata_ff[7]) begin
			idc_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Trap controls and prefix reporting
	// ----------------------------------------------------------------
	// trapctrl: [0] monitor enable, [1] hyp trap, [2] hyp enable,
	// [3] kernel enable, [4] host extension, [5] access is length register.
	logic vec_trap;
	assign vec_trap = !trapctrl_ff[0]
		|| (trapctrl_ff[4] ? !trapctrl_ff[2] : trapctrl_ff[1]) // R18
		|| !trapctrl_ff[3];

	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			trapctrl_ff <= 8'h0;
			synd_ff     <= 8'h0;
		end else if (wr_go && awaddr_ff == ADDR_TRAPCTRL && wstrb_ff[0]) begin
			trapctrl_ff <= wdata_ff[7:0];
			synd_ff     <= 8'h0;
		end else if (vec_trap) begin
			synd_ff <= {2'b01, VEC_TRAP_CLASS}; // R19
		end
	end

	// pfx: [0] prefix fetch abort, [1] prefixed fetch abort, [2] prefix changed
	// state, [3] event; addresses are taken from the scalar register word pair.
	logic [31:0] pfx_addr;
	assign pfx_addr = scalar_ff;
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			pfx_ff     <= 32'h0;
			restart_ff <= 32'h0;
			faddr_ff   <= 32'h0;
		end else if (wr_go && awaddr_ff == ADDR_PFX) begin
			pfx_ff <= wdata_ff;
			if (wdata_ff[3]) begin
				restart_ff <= wdata_ff[2] ? pfx_addr + 32'h4 : pfx_addr; // R21
				if (wdata_ff[0]) begin
					faddr_ff <= pfx_addr; // R22
				end else if (wdata_ff[1]) begin
					faddr_ff <= pfx_addr + 32'h4; // R22
				end
			end
		end
	end

	// A narrow scalar is written into the low byte; upper bits are cleared.
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			scalar_ff <= 32'h0;
		end else if (wr_go && awaddr_ff == ADDR_SCALAR) begin
			scalar_ff <= wstrb_ff == 4'hf ? wdata_ff : {24'h0, wdata_ff[7:0]}; // R7
		end
	end

	// ----------------------------------------------------------------
	// Responses
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= AXI_OKAY;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wr_known ? AXI_OKAY : AXI_DECERR;
		end else if (S_AXI_BREADY_I) begin
			bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0;
			rresp_ff  <= AXI_OKAY;
		end else if (rd_go) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= AXI_OKAY;
			case (S_AXI_ARADDR_I)
				ADDR_MASK:     rdata_ff <= mask_rd_ff;
				ADDR_PRED:     rdata_ff <= pred_ff;
				ADDR_FLAGS:    rdata_ff <= {25'h0, c_cont, c_lastnone, c_more, flags_ff};
				ADDR_FPCTRL:   rdata_ff <= {23'h0, idc_ff, 1'b0, fpctrl_ff[6:3],
					fpctrl_ff[2:0] & 3'h3}; // R17
				ADDR_TRAPCTRL: rdata_ff <= {23'h0, vec_trap, trapctrl_ff};
				ADDR_SYND:     rdata_ff <= {24'h0, synd_ff};
				ADDR_PFX:      rdata_ff <= pfx_ff;
				ADDR_RESTART:  rdata_ff <= restart_ff;
				ADDR_FADDR:    rdata_ff <= faddr_ff;
				ADDR_SCALAR:   rdata_ff <= scalar_ff;
				ADDR_CMD, ADDR_FAULT: rdata_ff <= 32'h0;
				default: begin
					rdata_ff <= 32'h0;
					rresp_ff <= AXI_DECERR;
				end
			endcase
		end else if (S_AXI_RREADY_I) begin
			rvalid_ff <= 1'b0;
		end
	end

endmodule : vffs_top
`default_nettype wire

// file: tb/vffs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module vffs_properties
	import vffs_pkg::*;
#(
	parameter int NBITS = VFFS_NBITS
) (
	input wire logic        CORE_CLK_I,
	input wire logic        SRST_I,
	input wire logic        S_AXI_AWVALID_I,
	input wire logic        S_AXI_AWREADY_O,
	input wire logic        S_AXI_WVALID_I,
	input wire logic        S_AXI_WREADY_O,
	input wire logic [1:0]  S_AXI_BRESP_O,
	input wire logic        S_AXI_BVALID_O,
	input wire logic        S_AXI_BREADY_I,
	input wire logic [11:0] S_AXI_ARADDR_I,
	input wire logic        S_AXI_ARVALID_I,
	input wire logic        S_AXI_ARREADY_O,
	input wire logic [31:0] S_AXI_RDATA_O,
	input wire logic [1:0]  S_AXI_RRESP_O,
	input wire logic        S_AXI_RVALID_O,
	input wire logic        S_AXI_RREADY_I
);
	// --------------------
	// Bus ordering checks.
	// --------------------
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (SRST_I);

	sequence s_wr_both;
		S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
	endsequence

	chk_b_after_both: assert property (s_wr_both |-> ##2 S_AXI_BVALID_O)
		else $error("write response late");
	chk_b_holds: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
		S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("write response dropped");
	chk_b_drops: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
		else $error("write response repeated");
	chk_b_blocks: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
		else $error("write taken while response pending");
	chk_r_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
		else $error("read answer late");
	chk_r_holds: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O &&
		$stable(S_AXI_RDATA_O) && $stable(S_AXI_RRESP_O)) else $error("read answer changed");
	chk_ar_gate: assert property (S_AXI_ARREADY_O != S_AXI_RVALID_O)
		else $error("read address ready wrong");
	chk_r_code: assert property ($rose(S_AXI_RVALID_O) |-> S_AXI_RRESP_O ==
		((($past(S_AXI_ARADDR_I) > ADDR_SCALAR) || ($past(S_AXI_ARADDR_I[1:0]) != 2'h0))
		? AXI_DECERR : AXI_OKAY))
		else $error("read response code wrong");
	chk_rst_idle: assert property ($fell(SRST_I) |->
		!S_AXI_BVALID_O && !S_AXI_RVALID_O && S_AXI_ARREADY_O) else $error("not idle after reset");
endmodule : vffs_properties

bind vffs_top vffs_properties #(.NBITS(NBITS)) chk_u (.CORE_CLK_I, .SRST_I, .S_AXI_AWVALID_I,
	.S_AXI_AWREADY_O, .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O,
	.S_AXI_BREADY_I, .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O,
	.S_AXI_RRESP_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I);
`default_nettype wire

// file: tb/vffs_axi_mst.sv
`timescale 1ns/1ps
`default_nettype none
module vffs_axi_mst (
	input  wire logic        clk_i,
	output logic [11:0]      awaddr_o,
	output logic             awvalid_o,
	input  wire logic        awready_i,
	output logic [31:0]      wdata_o,
	output logic [3:0]       wstrb_o,
	output logic             wvalid_o,
	input  wire logic        wready_i,
	input  wire logic        bvalid_i,
	input  wire logic [1:0]  bresp_i,
	output logic             bready_o,
	output logic [11:0]      araddr_o,
	output logic             arvalid_o,
	input  wire logic        arready_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic [1:0]  rresp_i,
	input  wire logic        rvalid_i,
	output logic             rready_o
);
	// --------------------
	// Pipeline side issuing.
	// --------------------
	logic [1:0] last_bresp;

	initial begin
		{awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
		{araddr_o, arvalid_o, rready_o} = '0;
		wstrb_o = 4'hf;
		last_bresp = 2'h0;
	end

	// Ready and valid are read at the rising edge, before that edge's updates land.
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
		logic pa;
		logic pw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge clk_i);
		awaddr_o  <= a;
		wdata_o   <= d;
		wstrb_o   <= s;
		awvalid_o <= 1'b1;
		wvalid_o  <= 1'b1;
		bready_o  <= 1'b1;
		while (pa || pw) begin
			@(posedge clk_i);
			if (pa && awready_i) begin
				awvalid_o <= 1'b0;
				pa = 1'b0;
			end
			if (pw && wready_i) begin
				wvalid_o <= 1'b0;
				pw = 1'b0;
			end
		end
		do @(posedge clk_i); while (!bvalid_i);
		last_bresp = bresp_i;
		bready_o <= 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		araddr_o  <= a;
		arvalid_o <= 1'b1;
		rready_o  <= 1'b1;
		do @(posedge clk_i); while (!arready_i);
		arvalid_o <= 1'b0;
		do @(posedge clk_i); while (!rvalid_i);
		d = rdata_i;
		r = rresp_i;
		rready_o <= 1'b0;
	endtask : rd
endmodule : vffs_axi_mst
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import vffs_pkg::*;
	// --------------------
	// Bench and expectations.
	// --------------------
	logic        clk, srst, awvalid_o, awready_i, wvalid_o, wready_i, bvalid_i, bready_o;
	logic        arvalid_o, arready_i, rvalid_i, rready_o;
	logic [11:0] awaddr_o, araddr_o;
	logic [31:0] wdata_o, rdata_i, seed;
	logic [3:0]  wstrb_o;
	logic [1:0]  rresp_i, bresp_i;
	int          err_count = 0;
	int          tests_run = 0;

	vffs_axi_mst mst_u (.clk_i(clk), .awaddr_o, .awvalid_o, .awready_i, .wdata_o, .wstrb_o,
		.wvalid_o, .wready_i, .bvalid_i, .bready_o, .araddr_o, .arvalid_o, .arready_i,
		.rdata_i, .rresp_i, .rvalid_i, .rready_o, .bresp_i);

	vffs_top dut_u (.CORE_CLK_I(clk), .SRST_I(srst), .S_AXI_AWADDR_I(awaddr_o),
		.S_AXI_AWVALID_I(awvalid_o), .S_AXI_AWREADY_O(awready_i), .S_AXI_WDATA_I(wdata_o),
		.S_AXI_WSTRB_I(wstrb_o), .S_AXI_WVALID_I(wvalid_o), .S_AXI_WREADY_O(wready_i),
		.S_AXI_BRESP_O(bresp_i), .S_AXI_BVALID_O(bvalid_i), .S_AXI_BREADY_I(bready_o),
		.S_AXI_ARADDR_I(araddr_o), .S_AXI_ARVALID_I(arvalid_o), .S_AXI_ARREADY_O(arready_i),
		.S_AXI_RDATA_O(rdata_i), .S_AXI_RRESP_O(rresp_i), .S_AXI_RVALID_O(rvalid_i),
		.S_AXI_RREADY_I(rready_o));

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction : xs

	function automatic logic [31:0] low_mask(input logic [4:0] k);
		return (32'h1 << k) - 32'h1;
	endfunction : low_mask

	// Byte-sized elements; g picks the active ones, the lowest is first and the highest last.
	function automatic logic [31:0] flag_exp(input logic [31:0] m, input logic [31:0] g);
		logic n;
		logic z;
		logic c;
		int   f;
		int   l;
		f = -1;
		l = -1;
		for (int i = 0; i < 32; i++) begin
			if (g[i]) begin
				if (f < 0) begin
					f = i;
				end
				l = i;
			end
		end
		n = (f >= 0) ? m[f] : 1'b0;
		z = ((m & g) == 32'h0);
		c = (l >= 0) ? ~m[l] : 1'b1;
		return {25'h0, ~n, ~c | z, c & ~z, n, z, c, 1'b0};
	endfunction : flag_exp

	function automatic logic [31:0] stride(input logic [1:0] e);
		case (e)
			2'h0: return 32'hffff_ffff;
			2'h1: return 32'h5555_5555;
			2'h2: return 32'h1111_1111;
			default: return 32'h0101_0101;
		endcase
	endfunction : stride

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		if (err_count == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#200000;
		err_count++;
		end_sim();
	end

	initial begin
		logic [31:0] d;
		logic [31:0] p;
		logic [1:0]  r;
		logic [4:0]  k;
		logic [31:0] re;
		logic [31:0] fe;
		logic [7:0]  f;
		logic [4:0]  t;
		logic        tr;
		logic        hi;
		srst = 1'b1;
		seed = 32'h56;
		re = 32'h0;
		fe = 32'h0;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		mst_u.rd(ADDR_MASK, d, r);
		check(d, MASK_RST);
		mst_u.rd(12'h100, d, r);
		check({30'h0, r}, {30'h0, AXI_DECERR});
		mst_u.wr(12'h100, 32'h0);
		check({30'h0, mst_u.last_bresp}, {30'h0, AXI_DECERR});
		mst_u.wr(ADDR_PRED, 32'h0);
		check({30'h0, mst_u.last_bresp}, {30'h0, AXI_OKAY});
		mst_u.wr(ADDR_FPCTRL, 32'h7);
		mst_u.rd(ADDR_FPCTRL, d, r);
		check({29'h0, d[2:0]}, 32'h3);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			p = (i == 2) ? 32'h0 : seed;
			k = (i == 0) ? 5'd0 : (i == 1) ? 5'd31 : seed[12:8];
			mst_u.wr(ADDR_CMD, 32'h1);
			mst_u.wr(ADDR_FAULT, {27'h0, k});
			mst_u.wr(ADDR_CMD, 32'h43);
			mst_u.rd(ADDR_MASK, d, r);
			check(d, low_mask(k));
			mst_u.wr(ADDR_PRED, p);
			mst_u.wr(ADDR_CMD, 32'h2);
			mst_u.wr(ADDR_CMD, 32'h44);
			mst_u.rd(ADDR_FLAGS, d, r);
			check({25'h0, d[6:0]}, flag_exp(p, 32'hffff_ffff));
			mst_u.wr(ADDR_FAULT, {27'h0, k});
			mst_u.wr(ADDR_CMD, 32'h3);
			mst_u.rd(ADDR_MASK, d, r);
			check(d, p & low_mask(k));
			mst_u.wr(ADDR_CMD, 32'h4);
			mst_u.rd(ADDR_FLAGS, d, r);
			check({25'h0, d[6:0]}, flag_exp(p & low_mask(k), p));
		end
		for (int e = 0; e < 4; e++) begin
			mst_u.wr(ADDR_CMD, {26'h0, e[1:0], 4'h1});
			mst_u.wr(ADDR_CMD, 32'h43);
			mst_u.rd(ADDR_MASK, d, r);
			check(d, stride(e[1:0]));
		end
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			mst_u.wr(ADDR_CMD, {23'h0, seed[8:7], 7'h6});
			tr = seed[7];
			hi = ~seed[7] & seed[8];
			mst_u.rd(ADDR_FLAGS, d, r);
			check({25'h0, d[6:0]}, {25'h0, tr == hi, 2'b10, tr, 2'b00, hi});
			mst_u.wr(ADDR_PRED, seed);
			mst_u.wr(ADDR_CMD, 32'h5);
			mst_u.rd(ADDR_FLAGS, d, r);
			check({25'h0, d[6:0]}, flag_exp(seed, seed));
			mst_u.wr(ADDR_SCALAR, seed, 4'h1);
			mst_u.rd(ADDR_SCALAR, d, r);
			check(d, {24'h0, seed[7:0]});
			mst_u.wr(ADDR_SCALAR, seed);
			mst_u.wr(ADDR_PFX, {28'h0, seed[3:0]});
			if (seed[3]) begin
				re = seed[2] ? seed + 32'h4 : seed;
				if (seed[0]) begin
					fe = seed;
				end else if (seed[1]) begin
					fe = seed + 32'h4;
				end
			end
			mst_u.rd(ADDR_RESTART, d, r);
			check(d, re);
			mst_u.rd(ADDR_FADDR, d, r);
			check(d, fe);
			t = (i == 0) ? 5'h0d : (i == 1) ? 5'h1d : seed[20:16];
			mst_u.wr(ADDR_TRAPCTRL, {27'h0, t});
			tr = ~t[0] | (t[4] ? ~t[2] : t[1]) | ~t[3];
			mst_u.rd(ADDR_TRAPCTRL, d, r);
			check(d, {23'h0, tr, 3'h0, t});
			mst_u.rd(ADDR_SYND, d, r);
			check({26'h0, d[5:0]}, tr ? {26'h0, VEC_TRAP_CLASS} : 32'h0);
			f = {1'b1, seed[30:24]};
			mst_u.wr(ADDR_FPCTRL, 32'h80);
			mst_u.wr(ADDR_FPCTRL, {24'h0, f});
			hi = f[5] & f[4] & ~(f[3] & f[1]) & ~(~f[3] & f[0]);
			mst_u.rd(ADDR_FPCTRL, d, r);
			check(d, {23'h0, hi, 1'b0, f[6:3], 1'b0, f[1:0]});
		end
		end_sim();
	end
endmodule : testbench
`default_nettype wire
